// ===== verilog/wrc_wakeup_reset_ctrl.sv
/*
 * Wakeup selection, pin wakeup, retention latch, watchdog gating and reset-cause
 * recording, with an AXI4-Lite register slave.
 * Assumes i_rst_n comes from the on-chip reset generator; pins, the low-frequency
 * clock and the reset pin are asynchronous; event inputs are one-cycle pulses on i_ref_clk.
 */
`timescale 1ns/1ps
module wrc_wakeup_reset_ctrl
   import wrc_pkg::*;
(
   input  wire logic              i_ref_clk,             // System clock, 50 MHz
   input  wire logic              i_rst_n,               // On-chip reset generator, async
   input  wire logic              i_rst_pin_n,           // Reset pin, async
   input  wire logic              i_wdt_reset,           // Watchdog reset pulse
   input  wire logic              i_lf_clk,              // Low-frequency clock, sampled
   input  wire logic [15:0]       i_wake_pins,           // {high reg pins, low reg pins}
   input  wire logic              i_slave_chip_select_n, // SPI slave select
   input  wire logic              i_radio_irq,           // Radio interrupt pulse
   input  wire logic              i_tick,                // Periodic tick pulse
   input  wire logic              i_xosc_ready,          // Fast crystal ready pulse
   input  wire logic              i_adc_done,            // Conversion done pulse
   input  wire logic              i_rng_ready,           // Random number ready pulse
   input  wire logic [15:0]       i_pin_setup,           // Setup to retain
   output logic [15:0]            o_pin_setup_ret,       // Retained setup
   output logic                   o_latch_lock,          // Retention latches locked
   output logic                   o_sys_reset,           // Start-up sequence running
   output logic                   o_wdt_hold,            // Watchdog forced to reset
   output logic                   o_wdt_run,             // Watchdog may run
   output logic [2:0]             o_power_mode,          // Current power-down mode
   output logic                   o_wake,                // Wakeup pulse
   output logic                   o_misc_irq,            // Miscellaneous interrupt pulse
   output logic                   o_pin_wake_irq,        // Pin wakeup interrupt level
   input  wire logic [ADDR_W-1:0] i_awaddr,              // AXI write address
   input  wire logic              i_awvalid,             // AXI
   output logic                   o_awready,             // AXI
   input  wire logic [31:0]       i_wdata,               // AXI write data
   input  wire logic [3:0]        i_wstrb,               // AXI byte strobes
   input  wire logic              i_wvalid,              // AXI
   output logic                   o_wready,              // AXI
   output logic [1:0]             o_bresp,               // AXI
   output logic                   o_bvalid,              // AXI
   input  wire logic              i_bready,              // AXI
   input  wire logic [ADDR_W-1:0] i_araddr,              // AXI read address
   input  wire logic              i_arvalid,             // AXI
   output logic                   o_arready,             // AXI
   output logic [31:0]            o_rdata,               // AXI read data
   output logic [1:0]             o_rresp,               // AXI
   output logic                   o_rvalid,              // AXI
   input  wire logic              i_rready               // AXI
);

   function automatic logic reg_is(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
      return a[ADDR_W-1:2] == {2'h0, idx};
   endfunction

   function automatic logic field_wakes(input logic [1:0] f, input logic irq, input logic en);
      case (f)
         WF_IF_EN:  field_wakes = irq & en;
         WF_ALWAYS: field_wakes = irq;
         default:   field_wakes = 1'b0;
      endcase
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return reg_is(a, IDX_PWR_DOWN) | reg_is(a, IDX_WAKE_SEL) | reg_is(a, IDX_OPM)
           | reg_is(a, IDX_RST_CAUSE) | reg_is(a, IDX_PIN_EN_HI) | reg_is(a, IDX_PIN_EN_LO)
           | reg_is(a, IDX_WAKE_CTRL) | reg_is(a, IDX_WAKE_STAT);
   endfunction

   wrc_opm_t          opm_q;
   wrc_wake_sel_t     wsel_q;
   wrc_wake_ctrl_t    wctl_q;
   logic [7:0]        pin_en_hi_q;
   logic [7:0]        pin_en_lo_q;
   logic [2:0]        cause_q;
   logic [2:0]        mode_q;
   logic [2:0]        prev_mode_q;
   logic              flag_pin_q;
   logic              flag_tick_q;

   // Synchronisers
   logic [15:0]       pins_s1_q, pins_s2_q;
   logic              csn_s1_q, csn_s2_q;
   logic              lf_s1_q, lf_s2_q, lf_s3_q;
   logic              rpin_s1_q, rpin_s2_q, rpin_s3_q;

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pins_s1_q <= 16'h0000;
         pins_s2_q <= 16'h0000;
         csn_s1_q  <= 1'b1;
         csn_s2_q  <= 1'b1;
         lf_s1_q   <= 1'b0;
         lf_s2_q   <= 1'b0;
         lf_s3_q   <= 1'b0;
         rpin_s1_q <= 1'b1;
         rpin_s2_q <= 1'b1;
         rpin_s3_q <= 1'b1;
      end else begin
         pins_s1_q <= i_wake_pins;
         pins_s2_q <= pins_s1_q;
         csn_s1_q  <= i_slave_chip_select_n;
         csn_s2_q  <= csn_s1_q;
         lf_s1_q   <= i_lf_clk;
         lf_s2_q   <= lf_s1_q;
         lf_s3_q   <= lf_s2_q;
         rpin_s1_q <= i_rst_pin_n;
         rpin_s2_q <= rpin_s1_q;
         rpin_s3_q <= rpin_s2_q;
      end
   end

   logic lf_fall;
   logic rst_pin_evt;
   assign lf_fall     = lf_s3_q & ~lf_s2_q;
   assign rst_pin_evt = rpin_s3_q & ~rpin_s2_q;

   // AXI write path: address and data taken in either order
   logic [ADDR_W-1:0] awaddr_q;
   logic [7:0]        wbyte_q;
   logic              wlane0_q, aw_have_q, w_have_q, bvalid_q;
   logic [1:0]        bresp_q;
   logic              do_write;

   assign o_awready = ~aw_have_q & ~bvalid_q;
   assign o_wready  = ~w_have_q & ~bvalid_q;
   assign do_write  = aw_have_q & w_have_q & ~bvalid_q;
   assign o_bvalid  = bvalid_q;
   assign o_bresp   = bresp_q;

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         awaddr_q  <= '0;
         wbyte_q   <= 8'h00;
         wlane0_q  <= 1'b0;
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end else begin
         if (i_awvalid && o_awready) begin
            awaddr_q  <= i_awaddr;
            aw_have_q <= 1'b1;
         end
         if (i_wvalid && o_wready) begin
            wbyte_q  <= i_wdata[7:0];
            wlane0_q <= i_wstrb[0];
            w_have_q <= 1'b1;
         end
         if (do_write) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_q && i_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   logic wr_lane;
   logic cause_wr;
   logic pd_wr;
   assign wr_lane  = do_write & wlane0_q;
   assign cause_wr = do_write & reg_is(awaddr_q, IDX_RST_CAUSE);
   assign pd_wr    = wr_lane & reg_is(awaddr_q, IDX_PWR_DOWN) & (wbyte_q[2:0] != PD_NONE)
                   & ((wbyte_q[2:0] <= PD_REGRET) | (wbyte_q[2:0] == PD_STANDBY));

   // Software-written configuration
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         opm_q       <= RST_OPM;
         wsel_q      <= RST_WAKE_SEL;
         wctl_q      <= RST_WAKE_CTRL;
         pin_en_hi_q <= RST_PIN_EN;
         pin_en_lo_q <= RST_PIN_EN;
      end else if (wr_lane) begin
         if (reg_is(awaddr_q, IDX_OPM))       opm_q       <= wbyte_q;
         if (reg_is(awaddr_q, IDX_WAKE_SEL))  wsel_q      <= wbyte_q;
         if (reg_is(awaddr_q, IDX_WAKE_CTRL)) wctl_q      <= {wbyte_q[7:1], 1'b0};
         if (reg_is(awaddr_q, IDX_PIN_EN_HI)) pin_en_hi_q <= wbyte_q;
         if (reg_is(awaddr_q, IDX_PIN_EN_LO)) pin_en_lo_q <= wbyte_q;
      end
   end

   // Reset cause: only the on-chip generator clears it by reset; events win over a clear
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cause_q <= RST_CAUSE;
      end else begin
         cause_q[CAUSE_PIN_BIT] <= rst_pin_evt | (cause_q[CAUSE_PIN_BIT] & ~cause_wr);
         cause_q[CAUSE_WDT_BIT] <= i_wdt_reset | (cause_q[CAUSE_WDT_BIT] & ~cause_wr);
         cause_q[2]             <= 1'b0;
      end
   end

   // Start-up sequence, shared by every reset source
   logic [7:0] seq_cnt_q;
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         seq_cnt_q <= 8'(RST_SEQ_CYCLES);
      end else if (rst_pin_evt || i_wdt_reset) begin
         seq_cnt_q <= 8'(RST_SEQ_CYCLES);
      end else if (seq_cnt_q != 8'h00) begin
         seq_cnt_q <= seq_cnt_q - 8'h01;
      end
   end
   assign o_sys_reset = (seq_cnt_q != 8'h00);

   // Pin wakeup, sampled on low-frequency falling edges
   logic [15:0] pins_lf_q;
   logic        csn_lf_q;
   logic [15:0] pol_mask, use_mask, pin_active;
   logic        pin_evt;

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pins_lf_q <= 16'h0000;
         csn_lf_q  <= 1'b1;
      end else if (lf_fall) begin
         pins_lf_q <= pins_s2_q;
         csn_lf_q  <= csn_s2_q;
      end
   end

   always_comb begin
      case (wctl_q.variant)
         PKG_MID: begin
            pol_mask = POL_MASK_MID;
            use_mask = USE_MASK_MID;
         end
         PKG_SMALL: begin
            pol_mask = POL_MASK_SMALL;
            use_mask = USE_MASK_SMALL;
         end
         default: begin
            pol_mask = POL_MASK_LARGE;
            use_mask = USE_MASK_LARGE;
         end
      endcase
   end

   assign pin_active = pins_lf_q ^ (opm_q.pol_low ? pol_mask : 16'h0000);
   assign pin_evt    = (|(pin_active & use_mask & {pin_en_hi_q, pin_en_lo_q}))
                     | (wctl_q.spi_slave_en & ~csn_lf_q);

   // Miscellaneous interrupt and pin interrupt
   logic misc_irq_q, pin_irq_q;
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         misc_irq_q <= 1'b0;
         pin_irq_q  <= 1'b0;
      end else begin
         misc_irq_q <= i_xosc_ready | i_adc_done | i_rng_ready;
         pin_irq_q  <= pin_evt;
      end
   end
   assign o_misc_irq     = misc_irq_q;
   assign o_pin_wake_irq = pin_irq_q;

   // Wake decision per mode
   logic standby_wake;
   logic wake_now;
   assign standby_wake = field_wakes(wsel_q.radio, i_radio_irq, wctl_q.radio_irq_en)
                       | field_wakes(wsel_q.tick, i_tick, wctl_q.tick_irq_en)
                       | field_wakes(wsel_q.pin, pin_irq_q, wctl_q.pin_irq_en)
                       | field_wakes(wsel_q.misc, misc_irq_q, wctl_q.misc_irq_en);

   always_comb begin
      case (mode_q)
         PD_STANDBY:                wake_now = standby_wake;
         PD_MEMRET_ON, PD_REGRET:   wake_now = pin_irq_q | i_tick;
         PD_DEEP, PD_MEMRET_OFF:    wake_now = pin_irq_q;
         default:                   wake_now = 1'b0;
      endcase
   end

   // Power-down mode tracking; read-clear wake flags
   logic rd_stat;
   logic wake_q;
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mode_q      <= PD_NONE;
         prev_mode_q <= PD_NONE;
         flag_pin_q  <= 1'b0;
         flag_tick_q <= 1'b0;
         wake_q      <= 1'b0;
      end else begin
         wake_q <= 1'b0;
         if (o_sys_reset) begin
            mode_q <= PD_NONE;
         end else if (mode_q != PD_NONE && wake_now) begin
            prev_mode_q <= mode_q;
            mode_q      <= PD_NONE;
            wake_q      <= 1'b1;
            flag_pin_q  <= flag_pin_q | pin_irq_q;
            flag_tick_q <= flag_tick_q | i_tick;
         end else if (pd_wr) begin
            mode_q      <= wbyte_q[2:0];
            flag_pin_q  <= 1'b0;
            flag_tick_q <= 1'b0;
         end else if (rd_stat) begin
            flag_pin_q  <= 1'b0;
            flag_tick_q <= 1'b0;
         end
      end
   end
   assign o_power_mode = mode_q;
   assign o_wake       = wake_q;

   // Watchdog gating
   logic wdt_hold_q, wdt_run_q;
   logic in_ret;
   assign in_ret = (mode_q == PD_MEMRET_OFF) | (mode_q == PD_MEMRET_ON) | (mode_q == PD_REGRET);
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wdt_hold_q <= 1'b0;
         wdt_run_q  <= 1'b1;
      end else begin
         wdt_hold_q <= opm_q.wdt_rst_en & in_ret;
         wdt_run_q  <= (mode_q != PD_DEEP) & ~(opm_q.wdt_rst_en & in_ret);
      end
   end
   assign o_wdt_hold = wdt_hold_q;
   assign o_wdt_run  = wdt_run_q;

   // Retention latches
   logic [15:0] setup_ret_q;
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         setup_ret_q <= 16'h0000;
      end else if (!opm_q.latch_lock) begin
         setup_ret_q <= i_pin_setup;
      end
   end
   assign o_pin_setup_ret = opm_q.latch_lock ? setup_ret_q : i_pin_setup;
   assign o_latch_lock    = opm_q.latch_lock;

   // AXI read path
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   logic        rvalid_q;
   logic [7:0]  rbyte;
   assign o_arready = ~rvalid_q;
   assign rd_stat   = i_arvalid & o_arready & reg_is(i_araddr, IDX_WAKE_STAT);

   always_comb begin
      rbyte = 8'h00;
      if (reg_is(i_araddr, IDX_PWR_DOWN))  rbyte = {5'h00, prev_mode_q};
      if (reg_is(i_araddr, IDX_WAKE_SEL))  rbyte = wsel_q;
      if (reg_is(i_araddr, IDX_OPM))       rbyte = opm_q;
      if (reg_is(i_araddr, IDX_RST_CAUSE)) rbyte = {5'h00, cause_q};
      if (reg_is(i_araddr, IDX_PIN_EN_HI)) rbyte = pin_en_hi_q;
      if (reg_is(i_araddr, IDX_PIN_EN_LO)) rbyte = pin_en_lo_q;
      if (reg_is(i_araddr, IDX_WAKE_CTRL)) rbyte = wctl_q;
      if (reg_is(i_araddr, IDX_WAKE_STAT)) rbyte = {flag_pin_q, flag_tick_q, 3'h0, mode_q};
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= RESP_OKAY;
         rvalid_q <= 1'b0;
      end else if (i_arvalid && o_arready) begin
         rdata_q  <= {24'h000000, rbyte};
         rresp_q  <= mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
         rvalid_q <= 1'b1;
      end else if (rvalid_q && i_rready) begin
         rvalid_q <= 1'b0;
      end
   end
   assign o_rdata  = rdata_q;
   assign o_rresp  = rresp_q;
   assign o_rvalid = rvalid_q;

   // Checks
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_seq_start;
      rst_pin_evt || i_wdt_reset;
   endsequence
   sequence s_seq_busy;
      o_sys_reset [*8];
   endsequence

   a_cause_write_clr: assert property (cause_wr && !rst_pin_evt && !i_wdt_reset |=> cause_q == 3'h0)
      else $error("reset cause not cleared by write");
   a_cause_pin_set: assert property (rst_pin_evt |=> cause_q[CAUSE_PIN_BIT])
      else $error("pin reset not recorded");
   a_cause_wdt_set: assert property (i_wdt_reset |=> cause_q[CAUSE_WDT_BIT] && !cause_q[2])
      else $error("watchdog reset not recorded");
   a_cause_accum_hold: assert property (cause_q[CAUSE_PIN_BIT] && !cause_wr |=> cause_q[CAUSE_PIN_BIT])
      else $error("reset cause lost");
   a_reset_seq_len: assert property (s_seq_start |=> s_seq_busy)
      else $error("start-up sequence too short");
   a_wdt_held_ret: assert property (opm_q.wdt_rst_en && in_ret |=> o_wdt_hold && !o_wdt_run)
      else $error("watchdog not held in retention");
   a_wdt_runs_free: assert property (!opm_q.wdt_rst_en && mode_q != PD_DEEP |=> o_wdt_run)
      else $error("watchdog stopped outside deep sleep");
   a_latch_holds: assert property (o_latch_lock && $past(o_latch_lock) |-> $stable(o_pin_setup_ret))
      else $error("locked latch changed");
   a_standby_ignore_all: assert property (mode_q == PD_STANDBY && wsel_q == 8'hFF && !o_sys_reset
                                          |=> mode_q == PD_STANDBY || $past(pd_wr))
      else $error("standby woke with all sources ignored");
   a_misc_irq_raise: assert property (i_xosc_ready || i_adc_done || i_rng_ready |=> o_misc_irq)
      else $error("misc interrupt not raised");

endmodule

// ===== verilog/wrc_pkg.sv
/*
 * Constants, register map and field layouts of the wakeup and reset-cause controller.
 * Assumes a 50 MHz system clock and register indices spaced one 32-bit word apart.
 */
package wrc_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0]  IDX_PWR_DOWN    = 8'hA4;
   localparam logic [7:0]  IDX_WAKE_SEL    = 8'hA5;
   localparam logic [7:0]  IDX_OPM         = 8'hAE;
   localparam logic [7:0]  IDX_RST_CAUSE   = 8'hB1;
   localparam logic [7:0]  IDX_PIN_EN_HI   = 8'hCE;
   localparam logic [7:0]  IDX_PIN_EN_LO   = 8'hCF;
   localparam logic [7:0]  IDX_WAKE_CTRL   = 8'hD0;
   localparam logic [7:0]  IDX_WAKE_STAT   = 8'hD1;

   localparam int unsigned ADDR_W          = 12;

   // Reset values
   localparam logic [7:0]  RST_WAKE_SEL    = 8'h00;
   localparam logic [7:0]  RST_OPM         = 8'h00;
   localparam logic [7:0]  RST_PIN_EN      = 8'h00;
   localparam logic [7:0]  RST_WAKE_CTRL   = 8'h00;
   localparam logic [2:0]  RST_CAUSE       = 3'h0;

   // Reset cause bit positions
   localparam int unsigned CAUSE_PIN_BIT   = 0;
   localparam int unsigned CAUSE_WDT_BIT   = 1;

   // Power-down mode codes
   localparam logic [2:0]  PD_NONE         = 3'h0;
   localparam logic [2:0]  PD_DEEP         = 3'h1;
   localparam logic [2:0]  PD_MEMRET_OFF   = 3'h2;
   localparam logic [2:0]  PD_MEMRET_ON    = 3'h3;
   localparam logic [2:0]  PD_REGRET       = 3'h4;
   localparam logic [2:0]  PD_STANDBY      = 3'h7;

   // Wake source field codes
   localparam logic [1:0]  WF_IF_EN        = 2'h0;
   localparam logic [1:0]  WF_ALWAYS       = 2'h2;
   localparam logic [1:0]  WF_IGNORE       = 2'h3;

   // Package variants, their polarity-selectable pins and their usable pins
   localparam logic [1:0]  PKG_LARGE       = 2'h0;
   localparam logic [1:0]  PKG_MID         = 2'h1;
   localparam logic [1:0]  PKG_SMALL       = 2'h2;
   localparam logic [15:0] POL_MASK_LARGE  = 16'h0044;
   localparam logic [15:0] POL_MASK_MID    = 16'h1440;
   localparam logic [15:0] POL_MASK_SMALL  = 16'h0040;
   localparam logic [15:0] USE_MASK_LARGE  = 16'hFFFF;
   localparam logic [15:0] USE_MASK_MID    = 16'h7FFF;
   localparam logic [15:0] USE_MASK_SMALL  = 16'h007F;

   // Reset and start-up sequence length
   localparam int unsigned CLK_PERIOD_NS   = 20;
   localparam int unsigned RST_SEQ_NS      = 200;
   localparam int unsigned RST_SEQ_CYCLES  = (RST_SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   typedef struct packed {
      logic [4:0] rsvd;
      logic       pol_low;
      logic       latch_lock;
      logic       wdt_rst_en;
   } wrc_opm_t;

   typedef struct packed {
      logic [1:0] radio;
      logic [1:0] tick;
      logic [1:0] pin;
      logic [1:0] misc;
   } wrc_wake_sel_t;

   typedef struct packed {
      logic [1:0] variant;
      logic       spi_slave_en;
      logic       misc_irq_en;
      logic       pin_irq_en;
      logic       tick_irq_en;
      logic       radio_irq_en;
      logic       rsvd;
   } wrc_wake_ctrl_t;

endpackage

// ===== bench/wrc_pins_model.sv
/* Far side: free-running slow clock and the reset pin.
   The bench asks for reset pin pulses. */
`timescale 1ns/1ps
module wrc_pins_model (
   input  wire logic i_clk,  // System clock
   input  wire logic i_rreq, // Pulse the pin
   output logic      o_lf,   // Slow clock
   output logic      o_rst_n // Reset pin
);
   int cnt = 0;
   // Offset keeps slow edges off the system clock edges, so sampling never races
   initial begin
      o_lf = 1'b0;
      #5;
      forever #170 o_lf = ~o_lf;
   end
   always @(posedge i_clk) cnt <= i_rreq ? 4 : (cnt > 0 ? cnt - 1 : 0);
   assign o_rst_n = (cnt == 0);
endmodule

// ===== bench/wrc_wakeup_reset_ctrl_tb.sv
/* Bench for the wakeup and reset-cause controller.
   Assumes wrc_pins_model for slow clock and reset pin. */
`timescale 1ns/1ps
module wrc_wakeup_reset_ctrl_tb;
   import wrc_pkg::*;
   typedef struct packed {logic [7:0] a, d, e; logic [1:0] r;} wrc_row_t;
   wrc_row_t    rows [7] = '{'{IDX_WAKE_SEL, 8'hE6, 8'hE6, RESP_OKAY}, '{IDX_OPM, 8'h04, 8'h04, RESP_OKAY},
      '{IDX_PIN_EN_HI, 8'hA5, 8'hA5, RESP_OKAY}, '{IDX_PIN_EN_LO, 8'h5A, 8'h5A, RESP_OKAY},
      '{IDX_RST_CAUSE, 8'hFF, 8'h00, RESP_OKAY}, '{IDX_WAKE_CTRL, 8'h3F, 8'h3E, RESP_OKAY},
      '{8'h10, 8'h77, 8'h00, RESP_SLVERR}};
   // {pin wake expected, select_n, pins}
   logic [17:0] seq [6] = '{18'h30000, 18'h10040, 18'h30042, 18'h10040, 18'h20040, 18'h10040};
   // {selector, radio, tick, xosc pulse, wakes}
   logic [11:0] sby [7] = '{12'hFFE, 12'h7F8, 12'h3F9, 12'hCF5, 12'hEF5, 12'hFE3, 12'hF31};
   logic        clk = 1'b0;
   logic        rst_n, wdt, rreq, awv, wv, arv, rdy, lf, rpn, lock, sysr, hold, run, wake, misc;
   logic        pwi, awr, wrd, bv, arr, rvl, rad, tck, csn;
   logic [1:0]  rrs, brs, rsp;
   logic [2:0]  ev, mode;
   logic [11:0] ad;
   logic [15:0] pins, setup, ret;
   logic [31:0] wd, rdat, rdv;
   int          miscompares = 0, checked = 0;
   wire  [4:0]  st = {lf, wake, sysr, pwi, misc};
   wrc_wakeup_reset_ctrl u_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_rst_pin_n(rpn), .i_wdt_reset(wdt),
      .i_lf_clk(lf), .i_wake_pins(pins), .i_slave_chip_select_n(csn), .i_radio_irq(rad), .i_tick(tck),
      .i_xosc_ready(ev[0]), .i_adc_done(ev[1]), .i_rng_ready(ev[2]), .i_pin_setup(setup),
      .o_pin_setup_ret(ret), .o_latch_lock(lock), .o_sys_reset(sysr), .o_wdt_hold(hold), .o_wdt_run(run),
      .o_power_mode(mode), .o_wake(wake), .o_misc_irq(misc), .o_pin_wake_irq(pwi), .i_awaddr(ad),
      .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hF), .i_wvalid(wv), .o_wready(wrd),
      .o_bresp(brs), .o_bvalid(bv), .i_bready(rdy), .i_araddr(ad), .i_arvalid(arv), .o_arready(arr),
      .o_rdata(rdat), .o_rresp(rrs), .o_rvalid(rvl), .i_rready(rdy));
   wrc_pins_model u_far (.i_clk(clk), .i_rreq(rreq), .o_lf(lf), .o_rst_n(rpn));
   initial forever #10 clk = ~clk;
   task automatic test_done(input bit to);
      if (to) miscompares++;
      if (miscompares == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, e);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, d);
      int n = 0;
      @(posedge clk);
      {ad, wd, awv, wv, arv, rdy} <= {2'b00, a, 2'b00, 24'h0, d, w, w, !w, 1'b1};
      do begin
         @(posedge clk);
         n++;
         if (awr) awv <= 1'b0;
         if (wrd) wv <= 1'b0;
         if (arr) arv <= 1'b0;
      end while (!(bv || rvl) && n < 100);
      rdy <= 1'b0;
      {rdv, rsp} = {rdat, w ? brs : rrs};
      if (n == 100) test_done(1);
   endtask
   task automatic wt(input int k, input logic v);
      int n;
      for (n = 0; st[k] !== v && n < 100; n++) @(posedge clk);
      if (n == 100) test_done(1);
   endtask
   initial begin
      {rst_n, wdt, rreq, rad, tck, awv, wv, arv, rdy, ev, ad, wd, pins} = '0;
      {csn, setup} = {1'b1, 16'h1234};
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      for (int k = 0; k < 7; k++) begin
         xfer(0, rows[k].a, 8'h00);
         chk("reset", rdv, 32'h0);
         xfer(1, rows[k].a, rows[k].d);
         chk("write response", {30'h0, rsp}, {30'h0, rows[k].r});
         xfer(0, rows[k].a, 8'h00);
         chk("value", {rdv[29:0], rsp}, {22'h0, rows[k].e, rows[k].r});
      end
      for (int k = 0; k < 6; k++) begin
         @(posedge clk) {csn, pins} <= seq[k][16:0];
         wt(1, seq[k][17]);
      end
      for (int k = 0; k < 2; k++) begin
         pins <= 16'h0040;
         xfer(1, IDX_OPM, {7'h02, k[0]});
         wt(4, 1'b1);
         wt(4, 1'b0);
         wt(1, 1'b0);
         xfer(1, IDX_PWR_DOWN, k ? 8'h04 : 8'h01);
         @(posedge clk) chk("sleep", {27'h0, mode, run, hold}, {27'h0, k ? PD_REGRET : PD_DEEP, 1'b0, k[0]});
         pins <= 16'h0042;
         wt(3, 1'b1);
      end
      xfer(1, IDX_OPM, 8'h02);
      setup <= 16'hABCD;
      @(posedge clk) chk("held", {15'h0, lock, ret}, {16'h1, 16'h1234});
      xfer(1, IDX_OPM, 8'h00);
      chk("open", {16'h0, ret}, {16'h0, 16'hABCD});
      for (int k = 0; k < 3; k++) begin
         @(posedge clk) ev <= 3'b001 << k;
         @(posedge clk) ev <= 3'b000;
         @(posedge clk) chk("misc", {31'h0, misc}, 32'h1);
         @(posedge clk) chk("misc pulse", {31'h0, misc}, 32'h0);
      end
      for (int k = 0; k < 7; k++) begin
         xfer(1, IDX_WAKE_SEL, sby[k][11:4]);
         xfer(1, IDX_PWR_DOWN, 8'h07);
         @(posedge clk) {rad, tck, ev[0]} <= sby[k][3:1];
         @(posedge clk) {rad, tck, ev[0]} <= 3'b000;
         repeat (2) @(posedge clk);
         chk("standby", {29'h0, mode}, {29'h0, sby[k][0] ? PD_NONE : PD_STANDBY});
      end
      xfer(0, IDX_WAKE_STAT, 8'h00);
      chk("status", rdv, 32'h80);
      xfer(0, IDX_WAKE_STAT, 8'h00);
      chk("status clear", rdv, 32'h0);
      xfer(0, IDX_PWR_DOWN, 8'h00);
      chk("previous", rdv, {29'h0, PD_STANDBY});
      for (int k = 0; k < 2; k++) begin
         @(posedge clk) {wdt, rreq} <= 2'b01 << k;
         @(posedge clk) {wdt, rreq} <= 2'b00;
         wt(2, 1'b1);
         wt(2, 1'b0);
         xfer(0, IDX_RST_CAUSE, 8'h00);
         chk("cause", rdv, 32'(2 * k + 1));
      end
      xfer(1, IDX_RST_CAUSE, 8'h5A);
      xfer(0, IDX_RST_CAUSE, 8'h00);
      chk("clear", rdv, 32'h0);
      test_done(0);
   end
endmodule
